/* dma_cycle_pkg.sv */
// types and constants shared by the disk data controller dma bus-cycle engine
// assumes a single bus clock; files that use these refer to them by full package name
package dma_cycle_pkg;

	localparam int ADDR_W      = 16;  // width of the multiplexed address/data bus
	localparam int HI_ADDR_W   = 32;  // local address width in extended addressing
	localparam int THR_W       = 6;   // width of the fifo threshold setting
	localparam int CNT_W       = 16;  // width of burst and block counts
	localparam int STD_STATES  = 4;   // states in a standard memory cycle
	localparam int EXT_STATES  = 5;   // states in an extended memory cycle

	// bus phases: idle, waiting for grant, then the memory cycle states
	typedef enum logic [2:0] {
		PH_IDLE = 3'h0,
		PH_WAIT = 3'h1,
		PH_T0   = 3'h2,
		PH_T1   = 3'h3,
		PH_T2   = 3'h4,
		PH_T3   = 3'h5,
		PH_T4   = 3'h6
	} phase_t;

	typedef enum logic {
		CH_LOCAL  = 1'h0,
		CH_REMOTE = 1'h1
	} chan_t;

	// pins toward buffer memory; oe_n low while the bus is driven
	typedef struct packed {
		logic [ADDR_W-1:0] data_out;
		logic              oe_n;
		logic              low_address_strobe;
		logic              high_address_strobe;
		logic              rd_n;
		logic              wr_n;
	} mem_pins_t;

	// static configuration of the engine
	typedef struct packed {
		logic             dual_channel;   // 0: single channel
		logic             addr32;         // 32-bit addressing, single channel only
		logic             word_mode;      // 1: word transfers
		logic             local_to_mem;   // 1: fifo data written to memory
		logic             remote_to_mem;  // 1: host data written to memory
		logic             remote_stream;  // 1: whole block in one stream
		logic [THR_W-1:0] fifo_threshold;
		logic [CNT_W-1:0] remote_burst_len;
	} dma_cfg_t;

	localparam mem_pins_t PINS_IDLE = '{data_out: 16'h0000, oe_n: 1'b1,
		low_address_strobe: 1'b0, high_address_strobe: 1'b0, rd_n: 1'b1, wr_n: 1'b1};

endpackage : dma_cycle_pkg

/* dma_addr_counter.sv */
// address counter for one dma channel, steps by one byte or one word
// assumes load and inc are never raised together by the caller
`timescale 1ns/1ps
module dma_addr_counter #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rstn,
	// control
	input  wire logic         load,
	input  wire logic [W-1:0] load_value,
	input  wire logic         word_step,
	input  wire logic         inc,
	// state
	output logic      [W-1:0] value,
	output logic              rolled
);

	typedef struct packed {
		logic [W-1:0] value;
		logic         rolled;
	} ctr_t;

	ctr_t st;
	ctr_t next_st;
	logic [16:0] low_sum;

	if (W < 16) begin : g_width_check
		$error("dma_addr_counter needs at least 16 address bits");
	end

	// rolled pulses when the low 16 bits wrap, so the upper half must be relatched
	always_comb begin
		next_st        = st;
		next_st.rolled = 1'b0;
		low_sum        = {1'b0, st.value[15:0]} + (word_step ? 17'h00002 : 17'h00001);
		if (load) begin
			next_st.value = load_value;
		end else if (inc) begin
			next_st.value  = st.value + W'(word_step ? 2 : 1);
			next_st.rolled = low_sum[16];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign value  = st.value;
	assign rolled = st.rolled;

endmodule : dma_addr_counter

/* dma_xfer_counter.sv */
// down counter of remaining transfers for a burst or a block
// assumes load wins over dec when both are raised
`timescale 1ns/1ps
module dma_xfer_counter #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rstn,
	// control
	input  wire logic         load,
	input  wire logic [W-1:0] load_value,
	input  wire logic         dec,
	// state
	output logic      [W-1:0] count,
	output logic              is_one,
	output logic              is_zero
);

	typedef struct packed {
		logic [W-1:0] count;
	} cnt_t;

	cnt_t st;
	cnt_t next_st;

	if (W < 2) begin : g_width_check
		$error("dma_xfer_counter needs at least two bits");
	end

	// never wraps below zero, so a stray decrement cannot restart a block
	always_comb begin
		next_st = st;
		if (load) begin
			next_st.count = load_value;
		end else if (dec && st.count != '0) begin
			next_st.count = st.count - W'(1);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign count   = st.count;
	assign is_one  = (st.count == W'(1));
	assign is_zero = (st.count == '0);

endmodule : dma_xfer_counter

/* disk_dma_bus_cycle_engine.sv */
// bus-cycle sequencer of the disk data controller on-chip dma
// assumes buffer memory and bus arbitration logic outside, all on the bus clock
//
// Functional notes
// - a standard memory cycle is exactly four states T1 to T4
// - low 16 address bits drive the bus from the edge opening T1
// - address bits 0-7 on lines 0-7, bits 8-15 on lines 8-15
// - low address strobe high during T1; memory latches on its fall
// - address removed at T2; read or write strobe held through T3
// - on memory writes the data is driven from T2 to end of T3
// - grant sampled at start of T4 decides next cycle or release
// - a grant lost before T4 still lets the current cycle finish
// - extended cycle adds T0 with upper address and high strobe
// - extended cycle only at block start and on low address rollover
// - raise channel request; cycles start only after matching grant
// - local request at fifo threshold; grant sampled each edge
// - local burst is threshold or half in word mode; stops on full/empty
// - last local cycle drops request at T2, releases after T4
// - remote channel moves data in bursts or as one stream
// - remote burst runs the programmed number of transfers after grant
// - last remote burst cycle drops request at T2, re-raises at T4 if more
// - stream mode keeps remote request until T2 of final cycle
// - grant withdrawn before T4 ends stream now, later after one more
// - local channel has priority over remote channel
`timescale 1ns/1ps
module disk_dma_bus_cycle_engine (
	// clock and reset
	input  wire logic                                     clk,
	input  wire logic                                     rstn,
	// configuration and channel control
	input  wire dma_cycle_pkg::dma_cfg_t                  cfg,
	input  wire logic                                     local_enable,
	input  wire logic                                     local_start,
	input  wire logic [dma_cycle_pkg::HI_ADDR_W-1:0]      local_start_addr,
	input  wire logic                                     remote_enable,
	input  wire logic                                     remote_start,
	input  wire logic [dma_cycle_pkg::ADDR_W-1:0]         remote_start_addr,
	input  wire logic [dma_cycle_pkg::CNT_W-1:0]          remote_block_len,
	// fifo side
	input  wire logic                                     fifo_at_threshold,
	input  wire logic                                     fifo_full,
	input  wire logic                                     fifo_empty,
	input  wire logic                                     fifo_one_left,
	input  wire logic                                     fifo_one_space,
	input  wire logic [dma_cycle_pkg::ADDR_W-1:0]         fifo_rdata,
	output logic                                          fifo_pop,
	output logic                                          fifo_push,
	// host port side
	input  wire logic [dma_cycle_pkg::ADDR_W-1:0]         host_wdata,
	output logic                                          host_pop,
	output logic                                          host_push,
	output logic [dma_cycle_pkg::ADDR_W-1:0]              read_data,
	// arbitration
	output logic                                          local_bus_request,
	input  wire logic                                     local_bus_grant,
	output logic                                          remote_bus_request,
	input  wire logic                                     remote_bus_grant,
	// buffer memory bus
	input  wire logic [dma_cycle_pkg::ADDR_W-1:0]         muxed_addr_data_bus_in,
	output dma_cycle_pkg::mem_pins_t                      mem_pins,
	// status
	output logic                                          owns_bus,
	output logic                                          remote_busy
);

	// whole engine state, registered as one word
	typedef struct packed {
		dma_cycle_pkg::phase_t                phase;
		dma_cycle_pkg::chan_t                 ch;
		logic                                 write;
		logic                                 grant_ok;
		logic                                 last;
		logic                                 need_hi;
		logic                                 local_req;
		logic                                 remote_req;
		logic                                 owns;
		logic                                 busy;
		logic                                 fifo_pop;
		logic                                 fifo_push;
		logic                                 host_pop;
		logic                                 host_push;
		logic [dma_cycle_pkg::ADDR_W-1:0]     read_data;
		dma_cycle_pkg::mem_pins_t             pins;
	} eng_t;

	eng_t st;
	eng_t next_st;

	logic [dma_cycle_pkg::HI_ADDR_W-1:0] local_addr;
	logic                                local_rolled;
	logic [dma_cycle_pkg::ADDR_W-1:0]    remote_addr;
	logic [dma_cycle_pkg::CNT_W-1:0]     local_burst_n;
	logic                                local_burst_one;
	logic                                remote_burst_one;
	logic                                remote_block_one;
	logic                                remote_block_zero;
	logic                                grant_now;
	logic                                loc_want;
	logic                                rem_want;
	logic                                start_burst;
	logic                                addr_inc;
	logic                                ext_mode;

	// pins for a given phase; everything idle outside the owned cycle
	function automatic dma_cycle_pkg::mem_pins_t drive_pins(
		input dma_cycle_pkg::phase_t                ph,
		input logic                                 wr,
		input logic [dma_cycle_pkg::HI_ADDR_W-1:0]  addr,
		input logic [dma_cycle_pkg::ADDR_W-1:0]     wdata
	);
		dma_cycle_pkg::mem_pins_t p;
		p = dma_cycle_pkg::PINS_IDLE;
		unique case (ph)
			dma_cycle_pkg::PH_T0: begin
				p.data_out            = addr[31:16];
				p.oe_n                = 1'b0;
				p.high_address_strobe = 1'b1;
			end
			dma_cycle_pkg::PH_T1: begin
				p.data_out           = addr[15:0];
				p.oe_n               = 1'b0;
				p.low_address_strobe = 1'b1;
			end
			// strobe and write data in T2 and T3
			dma_cycle_pkg::PH_T2, dma_cycle_pkg::PH_T3: begin
				p.data_out = wr ? wdata : '0;
				p.oe_n     = ~wr;
				p.rd_n     = wr;
				p.wr_n     = ~wr;
			end
			// not driving outside the address and data states
			dma_cycle_pkg::PH_IDLE, dma_cycle_pkg::PH_WAIT, dma_cycle_pkg::PH_T4: begin
				p = dma_cycle_pkg::PINS_IDLE;
			end
			default: begin
				p = dma_cycle_pkg::PINS_IDLE;
			end
		endcase
		return p;
	endfunction : drive_pins

	// local burst length: threshold, halved in word mode
	assign local_burst_n = dma_cycle_pkg::CNT_W'(cfg.word_mode ?
		(cfg.fifo_threshold >> 1) : cfg.fifo_threshold);

	// local wants the bus once fifo reaches threshold
	assign loc_want  = local_enable && fifo_at_threshold;
	// remote only exists in dual channel modes
	assign rem_want  = remote_enable && cfg.dual_channel && !remote_block_zero;
	assign grant_now = (st.ch == dma_cycle_pkg::CH_LOCAL) ? local_bus_grant : remote_bus_grant;
	assign ext_mode  = cfg.addr32 && !cfg.dual_channel;

	// a burst starts only on the matching grant while waiting
	assign start_burst = (st.phase == dma_cycle_pkg::PH_WAIT) && grant_now;
	// addresses and counts advance as T3 closes, ready before any next T0/T1
	assign addr_inc    = (st.phase == dma_cycle_pkg::PH_T3);

	dma_addr_counter #(
		.W (dma_cycle_pkg::HI_ADDR_W)
	) u_local_addr (
		.clk        (clk),
		.rstn       (rstn),
		.load       (local_start),
		.load_value (local_start_addr),
		.word_step  (cfg.word_mode),
		.inc        (addr_inc && st.ch == dma_cycle_pkg::CH_LOCAL),
		.value      (local_addr),
		.rolled     (local_rolled)
	);

	dma_addr_counter #(
		.W (dma_cycle_pkg::ADDR_W)
	) u_remote_addr (
		.clk        (clk),
		.rstn       (rstn),
		.load       (remote_start),
		.load_value (remote_start_addr),
		.word_step  (cfg.word_mode),
		.inc        (addr_inc && st.ch == dma_cycle_pkg::CH_REMOTE),
		.value      (remote_addr),
		.rolled     ()
	);

	dma_xfer_counter #(
		.W (dma_cycle_pkg::CNT_W)
	) u_local_burst (
		.clk        (clk),
		.rstn       (rstn),
		.load       (start_burst && st.ch == dma_cycle_pkg::CH_LOCAL),
		.load_value (local_burst_n),
		.dec        (addr_inc && st.ch == dma_cycle_pkg::CH_LOCAL),
		.count      (),
		.is_one     (local_burst_one),
		.is_zero    ()
	);

	// remote burst loaded with the programmed length
	dma_xfer_counter #(
		.W (dma_cycle_pkg::CNT_W)
	) u_remote_burst (
		.clk        (clk),
		.rstn       (rstn),
		.load       (start_burst && st.ch == dma_cycle_pkg::CH_REMOTE),
		.load_value (cfg.remote_burst_len),
		.dec        (addr_inc && st.ch == dma_cycle_pkg::CH_REMOTE),
		.count      (),
		.is_one     (remote_burst_one),
		.is_zero    ()
	);

	dma_xfer_counter #(
		.W (dma_cycle_pkg::CNT_W)
	) u_remote_block (
		.clk        (clk),
		.rstn       (rstn),
		.load       (remote_start),
		.load_value (remote_block_len),
		.dec        (addr_inc && st.ch == dma_cycle_pkg::CH_REMOTE),
		.count      (),
		.is_one     (remote_block_one),
		.is_zero    (remote_block_zero)
	);

	// next state of the sequencer
	always_comb begin
		next_st           = st;
		next_st.fifo_pop  = 1'b0;
		next_st.fifo_push = 1'b0;
		next_st.host_pop  = 1'b0;
		next_st.host_push = 1'b0;
		// upper half relatched at block start and on rollover
		if (local_start || local_rolled) begin
			next_st.need_hi = 1'b1;
		end
		// busy tracks the block counter's next value so the port stays a flop output
		next_st.busy = remote_start ? (remote_block_len != '0) : !(remote_block_zero ||
			(remote_block_one && addr_inc && st.ch == dma_cycle_pkg::CH_REMOTE));
		unique case (st.phase)
			dma_cycle_pkg::PH_IDLE: begin
				next_st.owns = 1'b0;
				if (loc_want) begin
					next_st.ch         = dma_cycle_pkg::CH_LOCAL;
					next_st.local_req  = 1'b1;
					next_st.remote_req = 1'b0;
					next_st.phase      = dma_cycle_pkg::PH_WAIT;
				end else if (rem_want) begin
					next_st.ch         = dma_cycle_pkg::CH_REMOTE;
					next_st.local_req  = 1'b0;
					next_st.remote_req = 1'b1;
					next_st.phase      = dma_cycle_pkg::PH_WAIT;
				end else begin
					next_st.local_req  = 1'b0;
					next_st.remote_req = 1'b0;
				end
			end
			dma_cycle_pkg::PH_WAIT: begin
				// grant sampled on every edge while requesting
				if (grant_now) begin
					next_st.owns  = 1'b1;
					next_st.write = (st.ch == dma_cycle_pkg::CH_LOCAL) ?
						cfg.local_to_mem : cfg.remote_to_mem;
					next_st.phase = dma_cycle_pkg::PH_T1;
				// a waiting remote request yields to local
				end else if (st.ch == dma_cycle_pkg::CH_REMOTE && loc_want) begin
					next_st.ch         = dma_cycle_pkg::CH_LOCAL;
					next_st.local_req  = 1'b1;
					next_st.remote_req = 1'b0;
				end
			end
			dma_cycle_pkg::PH_T0: begin
				next_st.phase = dma_cycle_pkg::PH_T1;
			end
			dma_cycle_pkg::PH_T1: begin
				next_st.phase = dma_cycle_pkg::PH_T2;
				if (st.ch == dma_cycle_pkg::CH_LOCAL) begin
					// burst count or fifo running out ends the burst
					next_st.last = local_burst_one ||
						(st.write ? fifo_one_left : fifo_one_space);
					if (next_st.last) begin
						next_st.local_req = 1'b0;
					end
				end else begin
					// burst or stream; stream ends with block
					next_st.last = remote_block_one ||
						(!cfg.remote_stream && remote_burst_one);
					if (next_st.last) begin
						next_st.remote_req = 1'b0;
					end
				end
			end
			dma_cycle_pkg::PH_T2: begin
				next_st.phase = dma_cycle_pkg::PH_T3;
			end
			dma_cycle_pkg::PH_T3: begin
				next_st.phase = dma_cycle_pkg::PH_T4;
				// grant sampled at the start of T4
				next_st.grant_ok = grant_now;
				// memory read data taken as the read strobe rises
				if (!st.write) begin
					next_st.read_data = muxed_addr_data_bus_in;
				end
				if (st.ch == dma_cycle_pkg::CH_LOCAL) begin
					next_st.fifo_pop  = st.write;
					next_st.fifo_push = ~st.write;
				end else begin
					next_st.host_pop  = st.write;
					next_st.host_push = ~st.write;
					// more of the block left: ask again from T4
					if (st.last && !remote_block_one) begin
						next_st.remote_req = 1'b1;
					end
				end
			end
			dma_cycle_pkg::PH_T4: begin
				// continue only on a granted T4
				if (st.grant_ok && !st.last &&
					!(st.ch == dma_cycle_pkg::CH_LOCAL && (st.write ? fifo_empty : fifo_full)) &&
					!(st.ch == dma_cycle_pkg::CH_LOCAL && loc_want == 1'b0 && !local_enable)) begin
					next_st.phase = dma_cycle_pkg::PH_T1;
				end else begin
					next_st.phase = dma_cycle_pkg::PH_IDLE;
					next_st.owns  = 1'b0;
					next_st.last  = 1'b0;
				end
			end
			default: begin
				next_st.phase = dma_cycle_pkg::PH_IDLE;
			end
		endcase
		// any new cycle of an extended local transfer may need T0
		if (next_st.phase == dma_cycle_pkg::PH_T1 &&
			(st.phase == dma_cycle_pkg::PH_WAIT || st.phase == dma_cycle_pkg::PH_T4) &&
			next_st.ch == dma_cycle_pkg::CH_LOCAL && ext_mode && next_st.need_hi) begin
			next_st.phase   = dma_cycle_pkg::PH_T0;
			next_st.need_hi = 1'b0;
		end
		// pins follow the phase being entered
		next_st.pins = drive_pins(next_st.phase, next_st.write,
			(next_st.ch == dma_cycle_pkg::CH_LOCAL) ? local_addr :
				{16'h0000, remote_addr},
			(next_st.ch == dma_cycle_pkg::CH_LOCAL) ? fifo_rdata : host_wdata);
	end

	// one register stage for all state; outputs come straight from it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st       <= '0;
			st.phase <= dma_cycle_pkg::PH_IDLE;
			st.pins  <= dma_cycle_pkg::PINS_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// every port below is a flop of the state word
	assign local_bus_request  = st.local_req;
	assign remote_bus_request = st.remote_req;
	assign mem_pins           = st.pins;
	assign fifo_pop           = st.fifo_pop;
	assign fifo_push          = st.fifo_push;
	assign host_pop           = st.host_pop;
	assign host_push          = st.host_push;
	assign read_data          = st.read_data;
	assign owns_bus           = st.owns;
	assign remote_busy        = st.busy;

endmodule : disk_dma_bus_cycle_engine

/* disk_dma_properties.sv */
// checker of memory-cycle and arbitration timing seen at the engine ports
// assumes the single bus clock; bound onto every engine instance below
`timescale 1ns/1ps
module disk_dma_properties (
	// clock and reset
	input wire logic                     clk,
	input wire logic                     rstn,
	// arbitration
	input wire logic                     local_bus_request,
	input wire logic                     local_bus_grant,
	input wire logic                     remote_bus_request,
	input wire logic                     remote_bus_grant,
	// memory bus and status
	input wire dma_cycle_pkg::mem_pins_t mem_pins,
	input wire logic                     owns_bus
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// strobe idle means neither read nor write is active
	wire logic las = mem_pins.low_address_strobe;
	wire logic idle_rw = mem_pins.rd_n & mem_pins.wr_n;

	AST_ADDR_T1: assert property (las |-> !mem_pins.oe_n ##1 (!las && !idle_rw))
		else $error("address phase not followed by strobe");
	AST_CYCLE_LEN: assert property (las |=> !las [*3])
		else $error("memory cycle shorter than four states");
	AST_STROBE_LEN: assert property ($fell(idle_rw) |-> $past(las) ##1 !idle_rw ##1 idle_rw)
		else $error("strobe not held for T2 and T3 only");
	AST_WRITE_DRIVE: assert property (!mem_pins.wr_n |-> !mem_pins.oe_n)
		else $error("write data not driven");
	AST_READ_FREE: assert property (!mem_pins.rd_n |-> mem_pins.oe_n)
		else $error("bus driven during read");
	AST_HIGH_ADDR: assert property (mem_pins.high_address_strobe |-> !mem_pins.oe_n ##1 las)
		else $error("high address state not before T1");
	AST_IDLE_QUIET: assert property (!owns_bus |-> mem_pins.oe_n && idle_rw && !las)
		else $error("bus active without ownership");
	AST_GRANT_FIRST: assert property ($rose(owns_bus) |-> $past(local_bus_request
		&& local_bus_grant || remote_bus_request && remote_bus_grant))
		else $error("bus taken without grant");
	AST_LOCAL_DROP: assert property ($fell(local_bus_request) && owns_bus |-> !idle_rw && $past(las))
		else $error("local request not dropped at T2");
endmodule : disk_dma_properties

bind disk_dma_bus_cycle_engine disk_dma_properties u_disk_dma_properties (.clk(clk), .rstn(rstn),
	.local_bus_request(local_bus_request), .local_bus_grant(local_bus_grant),
	.remote_bus_request(remote_bus_request), .remote_bus_grant(remote_bus_grant),
	.mem_pins(mem_pins), .owns_bus(owns_bus));

/* buf_mem_model.sv */
// buffer memory and bus arbiter model on the far side of the engine
// assumes read data is the latched address xor a fixed pattern
`timescale 1ns/1ps
module buf_mem_model (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rstn,
	// arbitration
	input  wire logic                     local_bus_request,
	input  wire logic                     remote_bus_request,
	input  wire logic                     hold_remote,
	output logic                          local_bus_grant,
	output logic                          remote_bus_grant,
	// memory bus
	input  wire dma_cycle_pkg::mem_pins_t mem_pins,
	output logic [15:0]                   bus_in,
	output logic [15:0]                   lo_addr,
	output logic [15:0]                   hi_addr,
	output logic [15:0]                   wr_data
);
	localparam logic [15:0] RD_XOR = 16'hA5A5;
	localparam logic [2:0] TD_CYC = 3'h5; // one clock plus a four-state cycle
	logic [15:0] last;
	logic [2:0]  td_left;
	// grant follows request a clock later, local first
	// after a preempting withdrawal, no other grant for Td
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			local_bus_grant <= 1'b0;
			remote_bus_grant <= 1'b0;
			last <= 16'h0000;
			td_left <= 3'h0;
		end else begin
			local_bus_grant <= local_bus_request && td_left == 3'h0;
			remote_bus_grant <= remote_bus_request && !local_bus_request && !hold_remote;
			last <= bus_in;
			if (remote_bus_grant && hold_remote) td_left <= TD_CYC;
			else if (td_left != 3'h0) td_left <= td_left - 3'h1;
		end
	end
	// latch both address halves while their strobes are high
	always_ff @(posedge clk) begin
		if (mem_pins.low_address_strobe) lo_addr <= mem_pins.data_out;
		if (mem_pins.high_address_strobe) hi_addr <= mem_pins.data_out;
		if (!mem_pins.wr_n) wr_data <= mem_pins.data_out;
	end
	// data only under the read strobe; otherwise a toggling pattern
	assign bus_in = !mem_pins.rd_n ? lo_addr ^ RD_XOR : ~last;
endmodule : buf_mem_model

/* tb_top.sv */
// self-checking bench: local write, extended read, remote burst and stream
// assumes the model answers reads with address xor A5A5
`timescale 1ns/1ps
module tb_top;
	logic clk, rstn, len, ren, lst, rst_s, thr, hold, femp;
	dma_cycle_pkg::dma_cfg_t cfg;
	dma_cycle_pkg::mem_pins_t pins;
	logic [31:0] laddr;
	logic [15:0] raddr, rlen, fdata, bus_in, lo, hi, wd, rdata;
	logic lreq, lgnt, rreq, rgnt, owns, rbusy, fpop, fpush, hpop, hpush;
	int num_errors = 0;
	int n_checks = 0;
	int pops, pushes, hpushes, hpops, cyc, i;

	disk_dma_bus_cycle_engine u_disk_dma_bus_cycle_engine (.clk(clk), .rstn(rstn), .cfg(cfg),
		.local_enable(len), .local_start(lst), .local_start_addr(laddr), .remote_enable(ren),
		.remote_start(rst_s), .remote_start_addr(raddr), .remote_block_len(rlen),
		.fifo_at_threshold(thr), .fifo_full(1'b0), .fifo_empty(femp), .fifo_one_left(1'b0),
		.fifo_one_space(1'b0), .fifo_rdata(fdata), .fifo_pop(fpop), .fifo_push(fpush),
		.host_wdata(16'h0005), .host_pop(hpop), .host_push(hpush), .read_data(rdata),
		.local_bus_request(lreq), .local_bus_grant(lgnt), .remote_bus_request(rreq),
		.remote_bus_grant(rgnt), .muxed_addr_data_bus_in(bus_in), .mem_pins(pins),
		.owns_bus(owns), .remote_busy(rbusy));
	buf_mem_model u_buf_mem_model (.clk(clk), .rstn(rstn), .local_bus_request(lreq),
		.remote_bus_request(rreq), .hold_remote(hold), .local_bus_grant(lgnt),
		.remote_bus_grant(rgnt), .mem_pins(pins), .bus_in(bus_in), .lo_addr(lo),
		.hi_addr(hi), .wr_data(wd));

	// bus clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// pulse counters and hang limit; the whole run needs well under 1000 cycles
	always @(posedge clk) begin
		cyc++;
		pops += fpop;
		pushes += fpush;
		hpushes += hpush;
		hpops += hpop;
		if (cyc == 4000) begin
			num_errors++;
			finish_test();
		end
	end

	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// one-cycle start pulse; counters cleared with it
	task start(input bit remote);
		pops = 0;
		pushes = 0;
		hpushes = 0;
		hpops = 0;
		if (remote) rst_s = 1'b1;
		else lst = 1'b1;
		@(negedge clk);
		lst = 1'b0;
		rst_s = 1'b0;
	endtask : start
	// threshold drops once requested, so one burst per local scenario
	task wait_idle();
		repeat (4) @(negedge clk);
		for (i = 0; i < 300 && (owns | lreq | rreq | rbusy) !== 1'b0; i++) begin
			if (lreq === 1'b1) thr = 1'b0;
			@(negedge clk);
		end
	endtask : wait_idle
	task finish_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : finish_test

	initial begin
		{rstn, len, ren, lst, rst_s, thr, hold, femp} = 8'h00;
		{cfg, laddr, raddr, rlen, fdata} = '0;
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		// byte write burst of three from the fifo
		cfg.local_to_mem = 1'b1;
		cfg.fifo_threshold = 6'h03;
		fdata = 16'h3C5A;
		laddr = 32'h00000010;
		start(1'b0);
		len = 1'b1;
		thr = 1'b1;
		wait_idle();
		chk("pops", 16'h0003, 16'(pops));
		chk("last addr", 16'h0012, lo);
		chk("write data", 16'h3C5A, wd);
		// extended read across the low-address rollover
		cfg = '0;
		cfg.addr32 = 1'b1;
		cfg.fifo_threshold = 6'h02;
		laddr = 32'h0001FFFF;
		start(1'b0);
		thr = 1'b1;
		wait_idle();
		chk("pushes", 16'h0002, 16'(pushes));
		chk("high addr", 16'h0002, hi);
		chk("low addr", 16'h0000, lo);
		chk("read data", 16'hA5A5, rdata);
		// write burst of four cut short by an empty fifo
		cfg = '0;
		cfg.local_to_mem = 1'b1;
		cfg.fifo_threshold = 6'h04;
		femp = 1'b1;
		start(1'b0);
		thr = 1'b1;
		wait_idle();
		chk("early end pops", 16'h0001, 16'(pops));
		femp = 1'b0;
		// remote bursts of two over a block of four
		len = 1'b0;
		cfg = '0;
		cfg.dual_channel = 1'b1;
		cfg.remote_burst_len = 16'h0002;
		raddr = 16'h0100;
		rlen = 16'h0004;
		ren = 1'b1;
		start(1'b1);
		wait_idle();
		chk("host pushes", 16'h0004, 16'(hpushes));
		chk("read data", 16'hA4A6, rdata);
		// stream preempted after its second transfer, then resumed
		cfg.remote_stream = 1'b1;
		raddr = 16'h0200;
		rlen = 16'h0006;
		start(1'b1);
		for (i = 0; i < 100 && hpushes == 0; i++) @(negedge clk);
		hold = 1'b1;
		for (i = 0; i < 100 && owns !== 1'b0; i++) @(negedge clk);
		chk("preempt pushes", 16'h0002, 16'(hpushes));
		chk("busy", 16'h0001, {15'h0000, rbusy});
		hold = 1'b0;
		wait_idle();
		chk("stream pushes", 16'h0006, 16'(hpushes));
		chk("read data", 16'hA7A0, rdata);
		// remote write of two transfers from the host port
		cfg.remote_to_mem = 1'b1;
		raddr = 16'h0300;
		rlen = 16'h0002;
		start(1'b1);
		wait_idle();
		chk("host pops", 16'h0002, 16'(hpops));
		chk("host write data", 16'h0005, wd);
		chk("host addr", 16'h0301, lo);
		finish_test();
	end
endmodule : tb_top
